// ### hdl/irs_pkg.sv
/*
  Shared constants and types for the expander reset/identity slave and
  the bus master that talks to it.
  Assumes one 25 MHz clock on both ends and a pulled-up two-wire bus.
*/
package irs_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_NS      = 40;
  localparam int unsigned SCL_HALF_NS = 500;
  localparam int unsigned SCL_HALF_CYC =
    (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] HALF_LAST = 4'(SCL_HALF_CYC - 1);

  // ****************************************
  // Bus addresses and bytes
  // ****************************************
  localparam logic [7:0] GC_BYTE    = 8'h00;
  localparam logic [7:0] SWRST_BYTE = 8'h06;
  localparam logic [6:0] ID_ADDR    = 7'h7C;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] TX_LAST    = 4'h7;
  localparam logic [1:0] ID_LAST    = 2'h2;
  localparam logic [7:0] PORT_RST   = 8'hFF;

  // Upper address nibble, indexed by which pins sit on SCL or SDA
  localparam logic [31:0] GRP_TBL = {4'hD, 4'h9, 4'h0, 4'hF,
                                     4'h6, 4'h1, 4'h8, 4'h7};
  localparam logic [1:0] CLS_SCL = 2'h2;
  localparam logic [1:0] CLS_SDA = 2'h3;

  // Identity word fields; values are arbitrary
  localparam logic [11:0] ID_MAKER = 12'h5A5;
  localparam logic [8:0]  ID_PART  = 9'h0C3;
  localparam logic [2:0]  ID_REV   = 3'h1;

  // ****************************************
  // Host register map
  // ****************************************
  localparam logic [7:0] CMD_OFS  = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam int unsigned CMD_NACK = 8;
  localparam int unsigned DATA_LSB = 16;
  localparam logic [1:0] OP_START = 2'h0;
  localparam logic [1:0] OP_STOP  = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h2;
  localparam logic [1:0] OP_READ  = 2'h3;
  localparam logic [4:0] PH_START_LAST = 5'h03;
  localparam logic [4:0] PH_STOP_LAST  = 5'h02;
  localparam logic [4:0] PH_BYTE_LAST  = 5'h11;

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [4:0] {
    DS_IDLE = 5'h01, DS_RX = 5'h02, DS_ACK = 5'h04,
    DS_TX   = 5'h08, DS_MACK = 5'h10
  } irs_dstate_t;

  typedef enum logic [5:0] {
    MD_ADDR = 6'h01, MD_GC = 6'h02, MD_GCX = 6'h04,
    MD_IDSEL = 6'h08, MD_WR = 6'h10, MD_RD = 6'h20
  } irs_mode_t;

  typedef enum logic [3:0] {
    HS_IDLE = 4'h1, HS_START = 4'h2, HS_STOP = 4'h4, HS_BYTE = 4'h8
  } irs_hstate_t;

endpackage

// ### hdl/irs_if.sv
/*
  Two-wire bus between the master and the slave end.
  Open-drain wires: a line is low while any party enables its driver.
*/
`timescale 1ns/1ps
interface irs_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Pull-ups win unless someone sinks the line
  assign scl = ~host_scl_oe;
  assign sda = ~(host_sda_oe | dev_sda_oe);

  modport host (
    output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
    input  scl, sda
  );
  modport dev (
    output dev_sda_o, dev_sda_oe,
    input  scl, sda
  );
endinterface

// ### hdl/irs_pin_class.sv
/*
  Classifies one address strap as ground, supply, SCL or SDA.
  Assumes scl_lvl and sda_lvl went through two flops, like the pin here.
*/
`timescale 1ns/1ps
module irs_pin_class
  import irs_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       pin,
  input  wire logic       scl_lvl,
  input  wire logic       sda_lvl,
  output logic [1:0]      cls
);
  logic pin_s1;
  logic pin_s2;
  logic diff_scl;
  logic diff_sda;

  // Equal sync depth keeps a strap tied to a bus line in step with it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Idle bus level, so a strap on SCL or SDA starts out in step
      pin_s1   <= 1'b1;
      pin_s2   <= 1'b1;
      diff_scl <= 1'b0;
      diff_sda <= 1'b0;
    end else begin
      pin_s1 <= pin;
      pin_s2 <= pin_s1;
      if (pin_s2 != scl_lvl) diff_scl <= 1'b1;
      if (pin_s2 != sda_lvl) diff_sda <= 1'b1;
    end
  end

  // Valid once a START and one clock low have been seen
  assign cls = !diff_scl ? CLS_SCL :
               !diff_sda ? CLS_SDA : {1'b0, pin_s2};
endmodule

// ### hdl/irs_device.sv
/*
  Slave end: strap address decode, general-call software reset,
  identity-word read and a minimal quasi-bidirectional port latch.
  Assumes a master that does not need clock stretching; the bus is
  sampled through two flops on hclk, so SCL halves must span several
  hclk periods.
*/
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps

// Function
// - ack general call 00h only for write
// - general call read is not acked
// - master sends exactly one 06h byte
// - ack general-call data only if 06h
// - no ack after first reset byte
// - STOP after reset byte restores defaults
// - repeated START cancels pending reset
// - master treats nack as reset abort
// - fixed 24-bit maker/part/revision word
// - master opens with identity address, write
// - only matching target acks target byte
// - master restarts with identity address, read
// - STOP then START abandons identity read
// - other slave addressed abandons identity read
// - maker first, then part, then revision
// - master nack ends identity read
// - continued acks wrap to first byte
// - never ack straps giving 7Ch or 00h
// - identity word cannot be written
// - defaults: port all high, bus idle
module irs_device
  import irs_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  irs_if.dev              bus,
  input  wire logic       addr_pin_high,
  input  wire logic       addr_pin_mid,
  input  wire logic       addr_pin_low,
  output logic [7:0]      port_out,
  output logic            soft_rst
);

  // ****************************************
  // Bus line synchronisers and edge events
  // ****************************************
  logic [1:0] ln_s1;
  logic [1:0] ln_s2;
  logic [1:0] ln_s3;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ln_s1 <= 2'b11;
      ln_s2 <= 2'b11;
      ln_s3 <= 2'b11;
    end else begin
      ln_s1 <= {bus.scl, bus.sda};
      ln_s2 <= ln_s1;
      ln_s3 <= ln_s2;
    end
  end

  wire scl_s    = ln_s2[1];
  wire sda_s    = ln_s2[0];
  wire scl_rise = scl_s & ~ln_s3[1];
  wire scl_fall = ~scl_s & ln_s3[1];
  wire start_ev = scl_s & ln_s3[1] & ~sda_s & ln_s3[0];
  wire stop_ev  = scl_s & ln_s3[1] & sda_s & ~ln_s3[0];

  // ****************************************
  // Strap address decode
  // ****************************************
  logic [1:0] cls_h;
  logic [1:0] cls_m;
  logic [1:0] cls_l;

  irs_pin_class u_cls_h (.hclk(hclk), .hresetn(hresetn),
    .pin(addr_pin_high), .scl_lvl(scl_s), .sda_lvl(sda_s), .cls(cls_h));
  irs_pin_class u_cls_m (.hclk(hclk), .hresetn(hresetn),
    .pin(addr_pin_mid), .scl_lvl(scl_s), .sda_lvl(sda_s), .cls(cls_m));
  irs_pin_class u_cls_l (.hclk(hclk), .hresetn(hresetn),
    .pin(addr_pin_low), .scl_lvl(scl_s), .sda_lvl(sda_s), .cls(cls_l));

  wire [2:0] bus_mask = {cls_h[1], cls_m[1], cls_l[1]};
  wire [4:0] grp_pos  = {bus_mask, 2'b00};
  wire [6:0] own_addr = {GRP_TBL[grp_pos +: 4],
                         cls_h[0], cls_m[0], cls_l[0]};
  // These two codes collide with reserved addresses
  wire own_ok = (own_addr != ID_ADDR) &&
                (own_addr != GC_BYTE[7:1]);

  // ****************************************
  // Identity word, constant by construction
  // ****************************************
  wire [23:0] id_word = {ID_MAKER, ID_PART, ID_REV};

  // ****************************************
  // Slave state
  // ****************************************
  irs_dstate_t state;
  irs_mode_t   mode;
  irs_mode_t   next_mode;
  logic [3:0]  bitcnt;
  logic [7:0]  shreg;
  logic [7:0]  txsh;
  logic        ack_r;
  logic        id_armed;
  logic        id_rd;
  logic        rst_pend;
  logic [1:0]  idx;
  logic        sda_oe;
  logic [7:0]  port_q;
  logic        ack_dec;
  logic [7:0]  rd_byte;
  logic [7:0]  id_byte;

  wire [6:0] rx_a  = shreg[7:1];
  wire       rx_rw = shreg[0];
  wire       id_hit = (rx_a == ID_ADDR);

  // Byte order on the wire: maker, then part, then revision
  always_comb begin
    case (idx)
      2'h0:    id_byte = id_word[23:16];
      2'h1:    id_byte = id_word[15:8];
      default: id_byte = id_word[7:0];
    endcase
  end

  assign rd_byte = id_rd ? id_byte : port_q;

  // ****************************************
  // Acknowledge decision at the end of a byte
  // ****************************************
  always_comb begin
    ack_dec   = 1'b0;
    next_mode = MD_ADDR;
    case (mode)
      MD_ADDR: begin
        if (shreg == GC_BYTE) begin
          ack_dec   = 1'b1;
          next_mode = MD_GC;
        end else if (id_hit && !rx_rw) begin
          ack_dec   = 1'b1;
          next_mode = MD_IDSEL;
        end else if (id_hit && id_armed) begin
          ack_dec   = 1'b1;
          next_mode = MD_RD;
        end else if (rx_a == own_addr && own_ok) begin
          ack_dec   = 1'b1;
          next_mode = rx_rw ? MD_RD : MD_WR;
        end
        // General call with read set falls through unacked
      end
      MD_GC: begin
        ack_dec   = (shreg == SWRST_BYTE);
        next_mode = MD_GCX;
      end
      MD_GCX: begin
        ack_dec   = 1'b0;
        next_mode = MD_GCX;
      end
      MD_IDSEL: begin
        ack_dec   = (rx_a == own_addr) && own_ok;
        next_mode = MD_ADDR;
      end
      MD_WR: begin
        ack_dec   = 1'b1;
        next_mode = MD_WR;
      end
      default: begin
        ack_dec   = 1'b0;
        next_mode = MD_ADDR;
      end
    endcase
  end

  // ****************************************
  // Bus sequencer
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state    <= DS_IDLE;
      mode     <= MD_ADDR;
      bitcnt   <= 4'h0;
      shreg    <= 8'h00;
      txsh     <= 8'h00;
      ack_r    <= 1'b0;
      id_armed <= 1'b0;
      id_rd    <= 1'b0;
      rst_pend <= 1'b0;
      idx      <= 2'h0;
      sda_oe   <= 1'b0;
      port_q   <= PORT_RST;
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= 1'b0;
      if (stop_ev) begin
        state    <= DS_IDLE;
        sda_oe   <= 1'b0;
        id_armed <= 1'b0;
        rst_pend <= 1'b0;
        if (rst_pend) begin
          port_q   <= PORT_RST;
          mode     <= MD_ADDR;
          soft_rst <= 1'b1;
        end
      end else if (start_ev) begin
        state    <= DS_RX;
        mode     <= MD_ADDR;
        bitcnt   <= 4'h0;
        sda_oe   <= 1'b0;
        rst_pend <= 1'b0;
      end else begin
        case (state)
          DS_RX: begin
            if (scl_rise && bitcnt != BYTE_BITS) begin
              shreg  <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == BYTE_BITS) begin
              state  <= DS_ACK;
              ack_r  <= ack_dec;
              sda_oe <= ack_dec;
              mode   <= next_mode;
              idx    <= 2'h0;
              case (mode)
                MD_ADDR: begin
                  id_rd <= id_hit;
                  if (!(id_hit && rx_rw)) id_armed <= 1'b0;
                end
                MD_IDSEL: id_armed <= ack_dec;
                MD_GC:    rst_pend <= ack_dec;
                MD_GCX:   rst_pend <= 1'b0;
                MD_WR:    port_q   <= shreg;
                default:  rst_pend <= rst_pend;
              endcase
            end
          end
          DS_ACK: begin
            if (scl_fall) begin
              bitcnt <= 4'h0;
              if (ack_r && mode == MD_RD) begin
                state  <= DS_TX;
                txsh   <= rd_byte;
                sda_oe <= ~rd_byte[7];
              end else begin
                state  <= ack_r ? DS_RX : DS_IDLE;
                sda_oe <= 1'b0;
              end
            end
          end
          DS_TX: begin
            if (scl_fall) begin
              if (bitcnt == TX_LAST) begin
                state  <= DS_MACK;
                sda_oe <= 1'b0;
              end else begin
                txsh   <= {txsh[6:0], 1'b0};
                sda_oe <= ~txsh[6];
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          DS_MACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                state    <= DS_IDLE;
                id_armed <= 1'b0;
              end else begin
                idx <= (idx == ID_LAST) ? 2'h0 : idx + 2'h1;
              end
            end else if (scl_fall) begin
              state  <= DS_TX;
              bitcnt <= 4'h0;
              txsh   <= rd_byte;
              sda_oe <= ~rd_byte[7];
            end
          end
          default: begin
            state  <= DS_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = sda_oe;
  assign port_out       = port_q;

endmodule

// ### hdl/irs_host.sv
/*
  Master end: AHB-Lite slave with a command and a status register,
  driving START, STOP, byte write and byte read on the two-wire bus.
  Assumes a slave that never stretches the clock; software sequences
  the reset and identity transactions from single commands.
*/
`timescale 1ns/1ps
module irs_host
  import irs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  irs_if.host              bus,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);

  // ****************************************
  // AHB-Lite slave, zero wait states
  // ****************************************
  irs_hstate_t state;
  logic        wr_pend;
  logic [7:0]  wr_ofs;
  logic        ack_rcv;
  logic [7:0]  rx_q;

  wire busy     = (state != HS_IDLE);
  wire addr_ph  = hsel & htrans[1] & hready;
  wire cmd_wr   = wr_pend && (wr_ofs == CMD_OFS);
  // Commands written while busy are dropped
  wire go       = cmd_wr && !busy;
  wire [1:0] op = hwdata[1:0];
  wire [31:0] stat_word = {16'h0000, rx_q, 6'h00, ack_rcv, busy};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_ofs  <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else begin
      wr_pend <= addr_ph & hwrite;
      wr_ofs  <= haddr[7:0];
      if (addr_ph && !hwrite)
        hrdata <= (haddr[7:0] == STAT_OFS) ? stat_word : 32'h0000_0000;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ****************************************
  // Bit engine
  // ****************************************
  logic [3:0] cnt;
  logic [4:0] phase;
  logic [4:0] ph_last;
  logic [8:0] sh;
  logic [8:0] rx;
  logic       scl_oe;
  logic       sda_oe;
  logic       scl_d;
  logic       sda_d;

  wire tick = (cnt == HALF_LAST);

  always_comb begin
    ph_last = PH_BYTE_LAST;
    scl_d   = scl_oe;
    sda_d   = sda_oe;
    case (state)
      HS_START: begin
        ph_last = PH_START_LAST;
        scl_d   = (phase == 5'h00) || (phase == PH_START_LAST);
        sda_d   = phase[1];
      end
      HS_STOP: begin
        ph_last = PH_STOP_LAST;
        scl_d   = (phase == 5'h00);
        sda_d   = (phase != PH_STOP_LAST);
      end
      HS_BYTE: begin
        scl_d = ~phase[0];
        sda_d = ~sh[8];
      end
      default: begin
        scl_d = scl_oe;
        sda_d = sda_oe;
      end
    endcase
  end

  // Reset and identity sequences are strings of these commands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state   <= HS_IDLE;
      cnt     <= 4'h0;
      phase   <= 5'h00;
      sh      <= 9'h1FF;
      rx      <= 9'h000;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
      ack_rcv <= 1'b0;
      rx_q    <= 8'h00;
    end else begin
      scl_oe <= scl_d;
      sda_oe <= sda_d;
      if (state == HS_IDLE) begin
        cnt   <= 4'h0;
        phase <= 5'h00;
        if (go) begin
          case (op)
            OP_START: state <= HS_START;
            OP_STOP:  state <= HS_STOP;
            default:  state <= HS_BYTE;
          endcase
          sh <= (op == OP_READ) ? {8'hFF, hwdata[CMD_NACK]}
                                : {hwdata[DATA_LSB +: 8], 1'b1};
        end
      end else if (tick) begin
        cnt <= 4'h0;
        if (state == HS_BYTE && phase[0]) begin
          rx <= {rx[7:0], bus.sda};
          sh <= {sh[7:0], 1'b1};
        end
        if (phase == ph_last) begin
          state <= HS_IDLE;
          if (state == HS_BYTE) begin
            // A missing ack aborts the sequence in software
            ack_rcv <= ~bus.sda;
            // The last sample is the ack bit, not part of the byte
            rx_q    <= rx[7:0];
          end
        end else begin
          phase <= phase + 5'h01;
        end
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end

  assign bus.host_scl_o  = 1'b0;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_scl_oe = scl_oe;
  assign bus.host_sda_oe = sda_oe;

endmodule

// ### tb/irs_checker.sv
/*
  Link checker for the two-wire bus joining irs_host and irs_device.
  Assumes the open-drain resolution of irs_if and one hclk domain.
*/
`timescale 1ns/1ps
module irs_checker
  import irs_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       host_scl_oe,
  input  wire logic       host_sda_oe,
  input  wire logic       dev_sda_oe,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] port_out,
  input  wire logic       soft_rst
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ****************************************
  // Sequences
  // ****************************************
  sequence s_dev_sink;
    $rose(dev_sda_oe);
  endsequence
  sequence s_sink_held;
    dev_sda_oe [*8];
  endsequence
  sequence s_stop_seen;
    scl && $rose(sda);
  endsequence

  // ****************************************
  // Properties
  // ****************************************
  a_wire_sda: assert property (
    sda == !(host_sda_oe | dev_sda_oe))
    else $error("sda level disagrees with drivers");
  a_data_scl_low: assert property (
    $changed(dev_sda_oe) |-> !scl)
    else $error("device moved sda while scl high");
  a_ack_held: assert property (
    s_dev_sink |-> s_sink_held)
    else $error("device sink too short");
  a_rst_pulse: assert property (
    soft_rst |=> !soft_rst)
    else $error("soft reset longer than one cycle");
  a_rst_port: assert property (
    soft_rst |-> ##[0:2] port_out == PORT_RST)
    else $error("port not restored by soft reset");
  a_rst_bus_idle: assert property (
    soft_rst |-> scl && sda && !dev_sda_oe)
    else $error("soft reset outside a stop");
  a_scl_half: assert property (
    $changed(host_scl_oe) |=> $stable(host_scl_oe) [*8])
    else $error("scl half period too short");
  a_stop_release: assert property (
    s_stop_seen |=> !dev_sda_oe [*3])
    else $error("device sinks sda after stop");
endmodule

// ### tb/irs_tb.sv
/*
  Bench: AHB-Lite commands to the host end, device end on the wire.
  Assumes all straps low until the second reset, so the device answers at 38h (byte 70h).
*/
`timescale 1ns/1ps
module irs_tb
  import irs_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic        strap;
  logic        hi_sda;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] rd;
  logic [31:0] st;
  logic [23:0] idw;
  wire         hreadyout;
  wire         hresp;
  wire         soft_rst;
  wire  [31:0] hrdata;
  wire  [7:0]  port_out;
  int          miscompares;
  int          checked;
  int          rst_cnt;
  int          n;

  irs_if bus ();
  irs_host u_irs_host (.hclk(hclk), .hresetn(hresetn), .bus(bus),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  irs_device u_irs_device (.hclk(hclk), .hresetn(hresetn), .bus(bus),
    .addr_pin_high(hi_sda ? bus.sda : strap), .addr_pin_mid(strap),
    .addr_pin_low(strap),
    .port_out(port_out), .soft_rst(soft_rst));
  irs_checker u_irs_checker (.hclk(hclk), .hresetn(hresetn),
    .host_scl_oe(bus.host_scl_oe), .host_sda_oe(bus.host_sda_oe),
    .dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda),
    .port_out(port_out), .soft_rst(soft_rst));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // Sampled away from the edge that launches the pulse
  always @(negedge hclk) begin
    if (soft_rst === 1'b1)
      rst_cnt++;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Busy rises one cycle after the write, so polling waits one edge
  task op(input logic [1:0] o, input logic [7:0] b, input logic k);
    ahb(1'b1, CMD_OFS, {8'h0, b, 7'h0, k, 6'h0, o});
    @(posedge hclk);
    st = 32'h1;
    while (st[0] !== 1'b0) begin
      ahb(1'b0, STAT_OFS, 32'h0);
      st = rd;
    end
  endtask

  task bus_start;
    op(OP_START, 8'h00, 1'b0);
  endtask

  task bus_stop;
    op(OP_STOP, 8'h00, 1'b0);
  endtask

  task wb(input logic [7:0] b, input logic ack);
    op(OP_WRITE, b, 1'b0);
    check({31'h0, st[1]}, {31'h0, ack});
  endtask

  task rb(input logic k, input logic [7:0] e);
    op(OP_READ, 8'h00, k);
    check({24'h0, st[15:8]}, {24'h0, e});
  endtask

  task id_read;
    bus_start;
    wb(8'hF8, 1'b1);
    wb(8'h70, 1'b1);
    bus_start;
    wb(8'hF9, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rb(i == 3, idw[23 - 8 * (i % 3) -: 8]);
    end
    bus_stop;
  endtask

  task test_done;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************
  // Sequence of tests
  // ****************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    strap = 1'b0;
    hi_sda = 1'b0;
    miscompares = 0;
    checked = 0;
    rst_cnt = 0;
    idw = {ID_MAKER, ID_PART, ID_REV};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check({24'h0, port_out}, {24'h0, PORT_RST});
    check({30'h0, bus.scl, bus.sda}, 32'h3);
    ahb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    bus_start;
    wb(8'h70, 1'b1);
    wb(8'h5A, 1'b1);
    bus_stop;
    bus_start;
    wb(8'h01, 1'b0);
    bus_stop;
    bus_start;
    wb(8'h00, 1'b1);
    wb(8'h07, 1'b0);
    bus_stop;
    check({24'h0, port_out}, 32'h5A);
    bus_start;
    wb(8'h00, 1'b1);
    wb(8'h06, 1'b1);
    bus_start;
    wb(8'h71, 1'b1);
    rb(1'b1, 8'h5A);
    bus_stop;
    check(32'(rst_cnt), 32'h0);
    bus_start;
    wb(8'h00, 1'b1);
    wb(8'h06, 1'b1);
    wb(8'h06, 1'b0);
    bus_stop;
    check({24'h0, port_out}, 32'h5A);
    bus_start;
    wb(8'h70, 1'b1);
    wb(8'h3C, 1'b1);
    bus_stop;
    n = rst_cnt;
    bus_start;
    wb(8'h00, 1'b1);
    wb(8'h06, 1'b1);
    bus_stop;
    check({24'h0, port_out}, {24'h0, PORT_RST});
    check(32'(rst_cnt - n), 32'h1);
    id_read;
    bus_start;
    wb(8'hF9, 1'b0);
    bus_stop;
    bus_start;
    wb(8'hF8, 1'b1);
    wb(8'h72, 1'b0);
    bus_stop;
    bus_start;
    wb(8'hF8, 1'b1);
    wb(8'h70, 1'b1);
    bus_stop;
    bus_start;
    wb(8'hF9, 1'b0);
    bus_stop;
    bus_start;
    wb(8'hF8, 1'b1);
    wb(8'h70, 1'b1);
    bus_start;
    wb(8'h72, 1'b0);
    bus_start;
    wb(8'hF9, 1'b0);
    bus_stop;
    bus_start;
    wb(8'hF8, 1'b1);
    wb(8'h70, 1'b1);
    op(OP_WRITE, 8'h00, 1'b0);
    bus_stop;
    id_read;
    check({31'h0, hresp}, 32'h0);
    // Second reset: high strap on SDA gives the reserved 7Ch
    hresetn <= 1'b0;
    hi_sda <= 1'b1;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus_start;
    wb(8'hF9, 1'b0);
    bus_stop;
    test_done;
  end

  // Expected run is some 12k cycles; give it a wide margin
  initial begin
    #2_000_000;
    miscompares++;
    test_done;
  end
endmodule
